// File: core/timer_channel.sv
// Behaviour
// - command enable bit enables counter clock unless disable bit set in same write
// - software trigger command resets the counter, except in up/down counting, and starts its clock
// - selector picks one of eight clocks; invert bit chooses counting edge
// - gating field ANDs selected clock with external clock line 0, 1 or 2
// - capture mode: loading capture B stops clock when stop bit set
// - capture mode: loading capture B disables clock when disable bit set
// - capture mode: trigger edge field selects none, rising, falling or both
// - capture mode: trigger source bit picks line A when one, B when zero
// - capture mode: compare C match triggers counter when trigger bit set
// - waveform select bit picks capture or waveform meaning of mode word
// - capture mode: edge field chooses which line A edge loads capture A
// - capture mode: second field chooses which line A edge loads capture B
// - waveform mode: compare C match stops clock when stop bit set
// - waveform mode: compare C match disables clock when disable bit set
// - waveform mode: event edge field selects none, rising, falling or both
// - waveform mode: event source picks line B or external clock line
// - waveform mode: event triggers counter only when event trigger bit set
// - waveform mode: shape selects up or up/down, with optional compare C trigger
// - waveform mode: compare A and compare C set, clear or toggle line A
// - waveform mode: event and software trigger set, clear or toggle line A
// - waveform mode: compare B sets, clears or toggles line B unless line B is the event source
// - waveform mode: compare C, event and software trigger act on line B unless it is the event source
// - up/down counting: a trigger reverses the counting direction
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "timer_channel_params.svh"

module timer_channel #(
    parameter int COUNTER_WIDTH = 16
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [`REG_ADDR_WIDTH-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [`REG_ADDR_WIDTH-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [4:0] internal_divided_clocks_in,
    input wire logic ext_clock_line_0_in,
    input wire logic ext_clock_line_1_in,
    input wire logic ext_clock_line_2_in,
    input wire logic channel_line_a_in,
    output timer_channel_pkg::line_drive_s channel_line_a_out,
    input wire logic channel_line_b_in,
    output timer_channel_pkg::line_drive_s channel_line_b_out
);
    import timer_channel_pkg::*;

    if (COUNTER_WIDTH < 2 || COUNTER_WIDTH > 32) begin : g_width_check
        $error("COUNTER_WIDTH must lie between 2 and 32");
    end

    localparam logic [COUNTER_WIDTH-1:0] COUNT_MAX = {COUNTER_WIDTH{1'b1}};

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic edge_hit(input logic [1:0] code, input logic rise, input logic fall);
        return (code[`EDGE_RISE_BIT] & rise) | (code[`EDGE_FALL_BIT] & fall);
    endfunction

    function automatic logic apply_action(input logic [1:0] act, input logic fire, input logic cur);
        logic res;
        res = cur;
        if (fire) begin
            case (act)
                `ACT_NONE: res = cur;
                `ACT_SET: res = 1'b1;
                `ACT_CLEAR: res = 1'b0;
                `ACT_TOGGLE: res = ~cur;
                default: res = cur;
            endcase
        end
        return res;
    endfunction

    // bus slave state
    logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg, wr_fire, wr_mapped, rd_mapped;
    logic [`REG_ADDR_WIDTH-1:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg, rd_value;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    // channel state
    logic [31:0] mode_reg;
    logic [COUNTER_WIDTH-1:0] count_reg, count_next, capt_a_reg, capt_b_reg, comp_c_reg, top_value;
    count_dir_e dir_reg, dir_next;
    logic clock_enabled_reg, running_reg, line_a_reg, line_b_reg, clk_level_prev_reg, edges_ready_reg;
    logic [4:0] io_prev_reg, io_now, io_rise, io_fall;
    logic [7:0] clock_sources;
    logic [2:0] trig_index;
    wave_mode_s wmode;
    capture_mode_s cmode;
    logic is_wave, cmd_wr, cmd_enable, cmd_disable, soft_trigger, clk_level, clk_tick, cnt_step;
    logic trig_rise, trig_fall, ext_event, ext_trigger, load_a, load_b, match_a, match_b, match_c;
    logic auto_trigger, any_trigger, stop_event, disable_event, updown, line_b_is_output;

    assign wmode = wave_mode_s'(mode_reg);
    assign cmode = capture_mode_s'(mode_reg);
    assign is_wave = wmode.waveform_select;

    // AXI4-Lite write path: address and data latched independently
    assign s_axi_awready_out = ~aw_hold_reg & ~bvalid_reg;
    assign s_axi_wready_out = ~w_hold_reg & ~bvalid_reg;
    assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;

    always_comb begin
        case (awaddr_reg)
            `OFF_COMMAND, `OFF_MODE, `OFF_COUNT, `OFF_CAPT_A, `OFF_CAPT_B, `OFF_COMP_C, `OFF_STATUS: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr_in;
            end else if (wr_fire) begin
                aw_hold_reg <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_in;
                wstrb_reg <= s_axi_wstrb_in;
            end else if (wr_fire) begin
                w_hold_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_DECERR;
            end else if (s_axi_bready_in) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path
    assign s_axi_arready_out = ~rvalid_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out = rdata_reg;
    assign s_axi_rresp_out = rresp_reg;

    always_comb begin
        rd_mapped = 1'b1;
        rd_value = '0;
        case (s_axi_araddr_in)
            `OFF_COMMAND: rd_value = '0;
            `OFF_MODE: rd_value = mode_reg;
            `OFF_COUNT: rd_value = 32'(count_reg);
            `OFF_CAPT_A: rd_value = 32'(capt_a_reg);
            `OFF_CAPT_B: rd_value = 32'(capt_b_reg);
            `OFF_COMP_C: rd_value = 32'(comp_c_reg);
            `OFF_STATUS: begin
                rd_value[`STAT_CLOCK_ENABLED_BIT] = clock_enabled_reg;
                rd_value[`STAT_LINE_A_BIT] = is_wave ? line_a_reg : channel_line_a_in;
                rd_value[`STAT_LINE_B_BIT] = line_b_is_output ? line_b_reg : channel_line_b_in;
                rd_value[`STAT_RUNNING_BIT] = running_reg;
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= rd_mapped ? `RESP_OKAY : `RESP_DECERR;
        end else if (s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    // command decode: one-cycle pulses, zero bits have no effect
    assign cmd_wr = wr_fire && awaddr_reg == `OFF_COMMAND && wstrb_reg[0];
    assign cmd_disable = cmd_wr && wdata_reg[`CMD_CLOCK_DISABLE_BIT];
    assign cmd_enable = cmd_wr && wdata_reg[`CMD_CLOCK_ENABLE_BIT] && !cmd_disable;
    assign soft_trigger = cmd_wr && wdata_reg[`CMD_SOFT_TRIGGER_BIT];

    // mode word and compare registers
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_reg <= `MODE_RESET;
        end else if (wr_fire && awaddr_reg == `OFF_MODE) begin
            mode_reg <= merge_bytes(mode_reg, wdata_reg, wstrb_reg);
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            comp_c_reg <= '0;
        end else if (wr_fire && awaddr_reg == `OFF_COMP_C) begin
            comp_c_reg <= COUNTER_WIDTH'(merge_bytes(32'(comp_c_reg), wdata_reg, wstrb_reg));
        end
    end

    // capture loads in capture mode, software writes in waveform mode
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            capt_a_reg <= '0;
        end else if (load_a) begin
            capt_a_reg <= count_reg;
        end else if (is_wave && wr_fire && awaddr_reg == `OFF_CAPT_A) begin
            capt_a_reg <= COUNTER_WIDTH'(merge_bytes(32'(capt_a_reg), wdata_reg, wstrb_reg));
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            capt_b_reg <= '0;
        end else if (load_b) begin
            capt_b_reg <= count_reg;
        end else if (is_wave && wr_fire && awaddr_reg == `OFF_CAPT_B) begin
            capt_b_reg <= COUNTER_WIDTH'(merge_bytes(32'(capt_b_reg), wdata_reg, wstrb_reg));
        end
    end

    // counter clock selection, gating and edge choice
    assign clock_sources = {ext_clock_line_2_in, ext_clock_line_1_in, ext_clock_line_0_in,
                            internal_divided_clocks_in};

    assign clk_level = clock_sources[wmode.clock_selector] &
        (wmode.clock_gate == `GATE_NONE || clock_sources[3'(wmode.clock_gate) + 3'd4]);

    // edge history, ignored for one cycle after reset
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            clk_level_prev_reg <= 1'b0;
            io_prev_reg <= '0;
            edges_ready_reg <= 1'b0;
        end else begin
            clk_level_prev_reg <= clk_level;
            io_prev_reg <= io_now;
            edges_ready_reg <= 1'b1;
        end
    end

    assign clk_tick = wmode.clock_invert ? (clk_level_prev_reg & ~clk_level)
                                         : (~clk_level_prev_reg & clk_level);
    assign cnt_step = clk_tick & clock_enabled_reg & running_reg & edges_ready_reg;

    // edge detection of lines A, B and external clock lines
    assign io_now = {ext_clock_line_2_in, ext_clock_line_1_in, ext_clock_line_0_in,
                     channel_line_b_in, channel_line_a_in};

    assign io_rise = io_now & ~io_prev_reg & {5{edges_ready_reg}};
    assign io_fall = ~io_now & io_prev_reg & {5{edges_ready_reg}};
    assign trig_index = is_wave ? 3'(wmode.event_source) + 3'd1
                                : {2'b00, ~cmode.trigger_source};
    assign trig_rise = io_rise[trig_index];
    assign trig_fall = io_fall[trig_index];

    assign ext_event = is_wave && edge_hit(wmode.event_edge, trig_rise, trig_fall);
    assign ext_trigger = is_wave ? (ext_event && wmode.event_trigger_enable)
                                 : edge_hit(cmode.trigger_edge, trig_rise, trig_fall);

    assign load_a = !is_wave && edge_hit(cmode.capture_a_edge, io_rise[0], io_fall[0]);
    assign load_b = !is_wave && edge_hit(cmode.capture_b_edge, io_rise[0], io_fall[0]);

    assign match_a = is_wave && cnt_step && count_reg == capt_a_reg;
    assign match_b = is_wave && cnt_step && count_reg == capt_b_reg;
    assign match_c = cnt_step && count_reg == comp_c_reg;

    assign auto_trigger = is_wave ? (match_c && wmode.counting_shape[`SHAPE_TRIGGER_BIT])
                                  : (match_c && cmode.compare_c_trigger);
    assign any_trigger = soft_trigger | ext_trigger | auto_trigger;

    assign stop_event = is_wave ? (match_c && wmode.stop_on_compare_c)
                                : (load_b && cmode.stop_on_capture_b);
    assign disable_event = is_wave ? (match_c && wmode.disable_on_compare_c)
                                   : (load_b && cmode.disable_on_capture_b);

    // clock enable and run state
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            clock_enabled_reg <= 1'b0;
        end else if (cmd_disable || disable_event) begin
            clock_enabled_reg <= 1'b0;
        end else if (cmd_enable) begin
            clock_enabled_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            running_reg <= 1'b0;
        end else if (stop_event) begin
            running_reg <= 1'b0;
        end else if (any_trigger || cmd_enable) begin
            running_reg <= 1'b1;
        end
    end

    // counting shape
    assign updown = is_wave && wmode.counting_shape[`SHAPE_UPDOWN_BIT];
    assign top_value = wmode.counting_shape[`SHAPE_TRIGGER_BIT] ? comp_c_reg : COUNT_MAX;

    always_comb begin
        count_next = count_reg;
        dir_next = dir_reg;
        if (any_trigger && !updown) begin
            count_next = '0;
            dir_next = DIR_UP;
        end else begin
            if (any_trigger) begin
                dir_next = (dir_reg == DIR_UP) ? DIR_DOWN : DIR_UP;
            end
            if (cnt_step) begin
                if (updown && dir_next == DIR_UP && count_reg == top_value) begin
                    dir_next = DIR_DOWN;
                end else if (updown && dir_next == DIR_DOWN && count_reg == '0) begin
                    dir_next = DIR_UP;
                end
                if (dir_next == DIR_UP) begin
                    count_next = count_reg + 1'b1;
                end else begin
                    count_next = count_reg - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_reg <= '0;
            dir_reg <= DIR_UP;
        end else begin
            count_reg <= count_next;
            dir_reg <= dir_next;
        end
    end

    // waveform output control
    assign line_b_is_output = is_wave && wmode.event_source != `EVENT_SRC_LINE_B;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            line_a_reg <= 1'b0;
        end else if (is_wave) begin
            line_a_reg <= apply_action(wmode.line_a_on_soft_trigger, soft_trigger,
                          apply_action(wmode.line_a_on_event, ext_event,
                          apply_action(wmode.line_a_on_compare_c, match_c,
                          apply_action(wmode.line_a_on_compare_a, match_a, line_a_reg))));
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            line_b_reg <= 1'b0;
        end else if (line_b_is_output) begin
            line_b_reg <= apply_action(wmode.line_b_on_soft_trigger, soft_trigger,
                          apply_action(wmode.line_b_on_event, ext_event,
                          apply_action(wmode.line_b_on_compare_c, match_c,
                          apply_action(wmode.line_b_on_compare_b, match_b, line_b_reg))));
        end
    end

    assign channel_line_a_out = '{level: line_a_reg, enable: is_wave};
    assign channel_line_b_out = '{level: line_b_reg, enable: line_b_is_output};

endmodule

// File: core/timer_channel_params.svh
`ifndef TIMER_CHANNEL_PARAMS_SVH
`define TIMER_CHANNEL_PARAMS_SVH

// register byte offsets inside the channel window
`define REG_ADDR_WIDTH 8
`define OFF_COMMAND 8'h00
`define OFF_MODE 8'h04
`define OFF_COUNT 8'h10
`define OFF_CAPT_A 8'h14
`define OFF_CAPT_B 8'h18
`define OFF_COMP_C 8'h1C
`define OFF_STATUS 8'h20

// command word bit positions
`define CMD_CLOCK_ENABLE_BIT 0
`define CMD_CLOCK_DISABLE_BIT 1
`define CMD_SOFT_TRIGGER_BIT 2

// status word bit positions
`define STAT_CLOCK_ENABLED_BIT 16
`define STAT_LINE_A_BIT 17
`define STAT_LINE_B_BIT 18
`define STAT_RUNNING_BIT 19

// reset values
`define MODE_RESET 32'h0000_0000

// edge select codes: bit 0 rising, bit 1 falling
`define EDGE_RISE_BIT 0
`define EDGE_FALL_BIT 1

// line action codes
`define ACT_NONE 2'h0
`define ACT_SET 2'h1
`define ACT_CLEAR 2'h2
`define ACT_TOGGLE 2'h3

// selector codes
`define EVENT_SRC_LINE_B 2'h0
`define GATE_NONE 2'h0
`define SHAPE_TRIGGER_BIT 1
`define SHAPE_UPDOWN_BIT 0

// bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// File: core/timer_channel_pkg.sv
package timer_channel_pkg;

    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_e;

    typedef struct packed {
        logic [1:0] line_b_on_soft_trigger;
        logic [1:0] line_b_on_event;
        logic [1:0] line_b_on_compare_c;
        logic [1:0] line_b_on_compare_b;
        logic [1:0] line_a_on_soft_trigger;
        logic [1:0] line_a_on_event;
        logic [1:0] line_a_on_compare_c;
        logic [1:0] line_a_on_compare_a;
        logic waveform_select;
        logic [1:0] counting_shape;
        logic event_trigger_enable;
        logic [1:0] event_source;
        logic [1:0] event_edge;
        logic disable_on_compare_c;
        logic stop_on_compare_c;
        logic [1:0] clock_gate;
        logic clock_invert;
        logic [2:0] clock_selector;
    } wave_mode_s;

    typedef struct packed {
        logic [11:0] unused_high;
        logic [1:0] capture_b_edge;
        logic [1:0] capture_a_edge;
        logic waveform_select;
        logic compare_c_trigger;
        logic [2:0] unused_mid;
        logic trigger_source;
        logic [1:0] trigger_edge;
        logic disable_on_capture_b;
        logic stop_on_capture_b;
        logic [1:0] clock_gate;
        logic clock_invert;
        logic [2:0] clock_selector;
    } capture_mode_s;

    typedef struct packed {
        logic level;
        logic enable;
    } line_drive_s;

endpackage

// File: bench/timer_channel_properties.sv
`timescale 1ns/1ps
module timer_channel_checker (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire timer_channel_pkg::line_drive_s channel_line_a_out,
    input wire timer_channel_pkg::line_drive_s channel_line_b_out
);
    import timer_channel_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_WR_BLOCK: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken during response");
    AST_WR_ANSWER: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
        |-> ##[1:2] s_axi_bvalid_out) else $error("write response late");
    AST_B_DROP: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
        else $error("write response repeated");
    AST_RD_BLOCK: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("read taken during answer");
    AST_AR_ANSWER: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    AST_R_DROP: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
        else $error("read answer repeated");
    AST_LINE_B: assert property (channel_line_b_out.enable |-> channel_line_a_out.enable)
        else $error("line b driven outside waveform mode");
    AST_MODE_STABLE: assert property (!$rose(s_axi_bvalid_out)
        |-> $stable(channel_line_a_out.enable) && $stable(channel_line_b_out.enable))
        else $error("drive enable moved without a write");
endmodule
bind timer_channel timer_channel_checker chk_i (.*);

// File: bench/timer_channel_partner.sv
`timescale 1ns/1ps
module timer_channel_partner (
    input wire logic clk_in,
    input wire logic run_in,
    input wire timer_channel_pkg::line_drive_s a_drv_in,
    input wire timer_channel_pkg::line_drive_s b_drv_in,
    output logic ext0_out,
    output logic a_pin_out,
    output logic b_pin_out
);
    import timer_channel_pkg::*;
    logic [1:0] phase_reg = 2'h0;
    initial ext0_out = 1'h0;
    // external clock toggles every two cycles in a burst, idles low between
    always @(posedge clk_in) begin
        phase_reg <= run_in ? phase_reg + 2'h1 : 2'h0;
        ext0_out <= run_in && (phase_reg[0] ? !ext0_out : ext0_out);
    end
    // pins pulled up when the channel releases them
    assign a_pin_out = a_drv_in.enable ? a_drv_in.level : 1'h1;
    assign b_pin_out = b_drv_in.enable ? b_drv_in.level : 1'h1;
endmodule

// File: bench/timer_channel_tb.sv
`timescale 1ns/1ps
`include "timer_channel_params.svh"
module timer_channel_tb;
    import timer_channel_pkg::*;
    logic clk_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0000_0000, s_axi_rdata_out, rdat;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
    logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, run = 1'h0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rrsp;
    logic [4:0] internal_divided_clocks_in = 5'h00;
    logic ext_clock_line_0_in, ext_clock_line_1_in = 1'h0, ext_clock_line_2_in = 1'h0;
    logic channel_line_a_in, channel_line_b_in;
    line_drive_s channel_line_a_out, channel_line_b_out;
    logic [2:0] cmds[5] = '{3'h3, 3'h0, 3'h1, 3'h0, 3'h2};
    logic ens[5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
    int err_total = 0, comparisons = 0;
    always #2 clk_in = !clk_in;
    always @(posedge clk_in) internal_divided_clocks_in <= internal_divided_clocks_in + 5'h01;
    timer_channel dut (.*);
    timer_channel_partner far (.clk_in(clk_in), .run_in(run), .a_drv_in(channel_line_a_out),
        .b_drv_in(channel_line_b_out), .ext0_out(ext_clock_line_0_in), .a_pin_out(channel_line_a_in),
        .b_pin_out(channel_line_b_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'h1;
        s_axi_wvalid_in <= 1'h1;
        s_axi_bready_in <= 1'h1;
        do @(posedge clk_in) begin
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
        end while (s_axi_awvalid_in || s_axi_wvalid_in);
        @(posedge clk_in iff s_axi_bvalid_out);
        s_axi_bready_in <= 1'h0;
        chk({30'h0, s_axi_bresp_out}, 32'h0000_0000);
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'h1;
        s_axi_rready_in <= 1'h1;
        @(posedge clk_in iff s_axi_arready_out);
        s_axi_arvalid_in <= 1'h0;
        @(posedge clk_in iff s_axi_rvalid_out);
        s_axi_rready_in <= 1'h0;
        rdat = s_axi_rdata_out;
        rrsp = s_axi_rresp_out;
        @(posedge clk_in);
    endtask
    task automatic burst(input int n);
        run <= 1'h1;
        repeat (4 * n) @(posedge clk_in);
        run <= 1'h0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        @(posedge clk_in);
        rd(`OFF_MODE);
        chk(rdat, `MODE_RESET);
        rd(8'h08);
        chk({rdat[29:0], rrsp}, {30'h0, `RESP_DECERR});
        $display("test registers done");
        wr(`OFF_MODE, 32'h0000_0005);
        wr(`OFF_COMMAND, 32'h0000_0001);
        burst(3);
        rd(`OFF_COUNT);
        chk(rdat, 32'h0000_0003);
        wr(`OFF_MODE, 32'h0000_000d);
        wr(`OFF_COMMAND, 32'h0000_0004);
        rd(`OFF_COUNT);
        chk(rdat, 32'h0000_0000);
        burst(2);
        rd(`OFF_COUNT);
        chk(rdat, 32'h0000_0002);
        $display("test counting done");
        wr(`OFF_COMP_C, 32'h0000_0002);
        wr(`OFF_MODE, 32'h0040_8045);
        rd(`OFF_MODE);
        chk(rdat, 32'h0040_8045);
        wr(`OFF_COMMAND, 32'h0000_0004);
        rd(`OFF_STATUS);
        chk(rdat & 32'h000a_0000, 32'h000a_0000);
        chk({31'h0, channel_line_a_out.level}, 32'h0000_0001);
        burst(4);
        rd(`OFF_STATUS);
        chk(rdat & 32'h0009_0000, 32'h0001_0000);
        wr(`OFF_COMMAND, 32'h0000_0004);
        rd(`OFF_STATUS);
        chk(rdat & 32'h0008_0000, 32'h0008_0000);
        $display("test waveform done");
        foreach (cmds[i]) begin
            wr(`OFF_COMMAND, {29'h0, cmds[i]});
            rd(`OFF_STATUS);
            chk({31'h0, rdat[16]}, {31'h0, ens[i]});
        end
        $display("test commands done");
        wr(`OFF_MODE, 32'h4030_9505);
        wr(`OFF_COMMAND, 32'h0000_0005);
        chk({30'h0, channel_line_b_out}, 32'h0000_0003);
        burst(3);
        rd(`OFF_STATUS);
        chk(rdat & 32'h000f_0000, 32'h000d_0000);
        rd(`OFF_COUNT);
        chk(rdat, 32'h0000_0000);
        $display("test events done");
        results();
    end
    // run needs well under a thousand cycles
    initial begin
        #20000;
        err_total++;
        results();
    end
endmodule
